/* logic/tgf_pkg.sv */
// tgf_pkg: register map, field layout, reset values and timing for the
// transmit gain / data format register bank.
// assumes a 32-bit APB slave; registers sit at index*4 byte addresses.
package tgf_pkg;

  // printed offsets are not all multiples of four: they are word indices
  localparam logic [7:0] TGF_IDX_FINE_TRIM = 8'h10;
  localparam logic [7:0] TGF_IDX_GAIN_LEVEL = 8'h11;
  localparam logic [7:0] TGF_IDX_UPDATE_CTRL = 8'h12;
  localparam logic [7:0] TGF_IDX_FORMAT = 8'h13;
  localparam logic [7:0] TGF_IDX_GAIN_STATUS = 8'h16;

  // byte address = index * 4
  localparam logic [9:0] TGF_ADDR_FINE_TRIM = {TGF_IDX_FINE_TRIM, 2'b00};
  localparam logic [9:0] TGF_ADDR_GAIN_LEVEL = {TGF_IDX_GAIN_LEVEL, 2'b00};
  localparam logic [9:0] TGF_ADDR_UPDATE_CTRL = {TGF_IDX_UPDATE_CTRL, 2'b00};
  localparam logic [9:0] TGF_ADDR_FORMAT = {TGF_IDX_FORMAT, 2'b00};
  localparam logic [9:0] TGF_ADDR_GAIN_STATUS = {TGF_IDX_GAIN_STATUS, 2'b00};

  // field positions
  localparam int TGF_BIT_SYNC_EN = 6;
  localparam int TGF_BIT_FAST = 4;
  localparam int TGF_BIT_TX_TWOS = 7;
  localparam int TGF_BIT_RX_TWOS = 6;
  localparam int TGF_BIT_TX_INV = 5;
  localparam int TGF_BIT_INTERP_LSB = 0;

  // reset values
  localparam logic [7:0] TGF_RST_GAIN = 8'hFF;
  localparam logic [5:0] TGF_RST_TRIM = 6'h00;
  localparam logic [7:0] TGF_RST_UPDATE = 8'h00;
  localparam logic [7:0] TGF_RST_FORMAT = 8'h00;

  // fine trim landmark codes
  localparam logic [5:0] TGF_TRIM_MAX_NEG = 6'h1F;
  localparam logic [5:0] TGF_TRIM_MAX_POS = 6'h20;

  // smooth ramp: one 0.1 dB step per step time
  localparam int TGF_CLK_MHZ = 20;
  localparam int TGF_RAMP_STEP_NS = 400;
  localparam int TGF_RAMP_STEP_CYC =
    (TGF_RAMP_STEP_NS * TGF_CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0]
  {
    TGF_INTERP_BYPASS = 2'b00,
    TGF_INTERP_X2 = 2'b01,
    TGF_INTERP_X4 = 2'b10,
    TGF_INTERP_UNDEF = 2'b11
  } tgf_interp_e;

  // datapath configuration seen by the converters
  typedef struct packed
  {
    logic tx_twos;
    logic rx_twos;
    logic tx_fall_edge;
    tgf_interp_e interp;
  } tgf_format_s;

endpackage

/* logic/tgf_gain_ramp.sv */
// tgf_gain_ramp: walks the applied gain code toward its target.
// assumes target is stable from the pclk domain.
`timescale 1ns/1ps
`default_nettype none
module tgf_gain_ramp
  import tgf_pkg::*;
#(
  parameter int STEP_CYC = TGF_RAMP_STEP_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] target,
  input wire logic fast,
  output logic [7:0] applied,
  output logic busy
);

  logic [15:0] step_cnt;

  assign busy = (applied != target);

  // step timer; a code step only when it expires
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      step_cnt <= 16'h0000;
    else if (!busy || fast || step_cnt == 16'(STEP_CYC - 1))
      step_cnt <= 16'h0000;
    else
      step_cnt <= step_cnt + 16'h0001;
  end

  // fast jumps in one cycle; smooth moves one 0.1 dB code per step
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      applied <= TGF_RST_GAIN;
    else if (busy && fast)
      applied <= target;
    else if (busy && step_cnt == 16'(STEP_CYC - 1))
      applied <= (target > applied) ? applied + 8'h01 : applied - 8'h01;
  end

  a_ramp_one_step: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(fast) && $past(busy) |->
    (applied == $past(applied)) || (applied == $past(applied) + 8'h01) ||
    (applied == $past(applied) - 8'h01))
    else $error("smooth ramp jumped more than one code");

  a_fast_settles: assert property (@(posedge pclk) disable iff (!presetn)
    fast && busy && $stable(target) |=> applied == $past(target))
    else $error("fast update did not settle in one cycle");

endmodule
`default_nettype wire

/* logic/tgf_regs.sv */
// tgf_regs: APB register bank for transmit gain, gain update mode,
// fine gain trim and data format / interpolation control.
// assumes tx_powerdown_pin is asynchronous; APB on pclk, 32-bit data.
`timescale 1ns/1ps
`default_nettype none
module tgf_regs
  import tgf_pkg::*;
#(
  parameter int RAMP_STEP_CYC = TGF_RAMP_STEP_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_powerdown_pin,
  output logic [7:0] tx_gain_stage,
  output logic [7:0] tx_gain_stage_b,
  output logic signed [5:0] fine_trim,
  output tgf_format_s format_cfg,
  output logic gain_ramping
);

  logic [7:0] tx_gain_level;
  logic [7:0] tx_gain_update_control;
  logic [7:0] io_format_config;
  logic [5:0] fine_trim_reg;
  logic [7:0] gain_target;
  logic gain_pending;
  logic pd_meta;
  logic pd_sync;
  logic pd_prev;
  logic pd_fall;
  logic wr_en;
  logic rd_en;
  logic addr_hit;
  logic [7:0] applied;
  logic ramp_busy;
  logic [31:0] next_prdata;
  logic addr_hi_zero;
  logic [7:0] reg_idx;
  logic sel_trim;
  logic sel_level;
  logic sel_update;
  logic sel_format;
  logic sel_status;
  logic level_write;

  wire gain_sync_enable = tx_gain_update_control[TGF_BIT_SYNC_EN];
  wire gain_fast_settle = tx_gain_update_control[TGF_BIT_FAST];

  // apb decode; zero wait states, error on unmapped word
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  // word index compared at its own width; upper address bits must be zero
  assign addr_hi_zero = (paddr[11:10] == 2'b00);
  assign reg_idx = paddr[9:2];
  assign sel_trim = addr_hi_zero && (reg_idx == TGF_IDX_FINE_TRIM);
  assign sel_level = addr_hi_zero && (reg_idx == TGF_IDX_GAIN_LEVEL);
  assign sel_update = addr_hi_zero && (reg_idx == TGF_IDX_UPDATE_CTRL);
  assign sel_format = addr_hi_zero && (reg_idx == TGF_IDX_FORMAT);
  assign sel_status = addr_hi_zero && (reg_idx == TGF_IDX_GAIN_STATUS);
  assign addr_hit = sel_trim || sel_level || sel_update || sel_format || sel_status;
  assign level_write = wr_en && pstrb[0] && sel_level;
  assign pslverr = psel && penable && (!addr_hit || (pwrite && sel_status));

  // fine trim, low byte lane only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fine_trim_reg <= TGF_RST_TRIM;
    else if (wr_en && pstrb[0] && sel_trim)
      fine_trim_reg <= pwdata[5:0];
  end
  // twos complement: 011111 is most negative adjustment, 100000 most positive
  assign fine_trim = $signed(fine_trim_reg);

  // gain level register, unsigned binary code
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_gain_level <= TGF_RST_GAIN;
    else if (level_write)
      tx_gain_level <= pwdata[7:0];
  end

  // update control register; only bits 6 and 4 are implemented
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_gain_update_control <= TGF_RST_UPDATE;
    else if (wr_en && pstrb[0] && sel_update)
      tx_gain_update_control <= pwdata[7:0] & 8'h50;
  end

  // format register; bits 4..2 belong to no function here and read zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      io_format_config <= TGF_RST_FORMAT;
    else if (wr_en && pstrb[0] && sel_format)
      io_format_config <= pwdata[7:0] & 8'hE3;
  end

  // power-down pin: two-flop synchroniser, then edge detect on stage two
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pd_meta <= 1'b0;
      pd_sync <= 1'b0;
      pd_prev <= 1'b0;
    end
    else
    begin
      pd_meta <= tx_powerdown_pin;
      pd_sync <= pd_meta;
      pd_prev <= pd_sync;
    end
  end
  assign pd_fall = pd_prev && !pd_sync;

  // target selection: immediate, or held until wake-up edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gain_target <= TGF_RST_GAIN;
      gain_pending <= 1'b0;
    end
    else if (!gain_sync_enable)
    begin
      gain_target <= tx_gain_level;
      gain_pending <= 1'b0;
    end
    else if (pd_fall)
    begin
      gain_target <= tx_gain_level;
      // set wins: a write landing with the edge waits for the next wake-up
      gain_pending <= level_write;
    end
    else if (level_write)
      gain_pending <= 1'b1;
  end

  // smooth or fast approach to the target
  tgf_gain_ramp #(
    .STEP_CYC(RAMP_STEP_CYC)
  ) u_ramp (
    .pclk(pclk),
    .presetn(presetn),
    .target(gain_target),
    .fast(gain_fast_settle),
    .applied(applied),
    .busy(ramp_busy)
  );

  // one code feeds both channels; 00 is -25.5 dB, FF is 0 dB
  assign tx_gain_stage = applied;
  assign tx_gain_stage_b = applied;
  assign gain_ramping = ramp_busy;

  // datapath format; code 11 passes through, behaviour left undefined
  assign format_cfg.tx_twos = io_format_config[TGF_BIT_TX_TWOS];
  assign format_cfg.rx_twos = io_format_config[TGF_BIT_RX_TWOS];
  assign format_cfg.tx_fall_edge = io_format_config[TGF_BIT_TX_INV];
  assign format_cfg.interp =
    tgf_interp_e'(io_format_config[TGF_BIT_INTERP_LSB +: 2]);

  // read mux, registered in the setup phase
  always_comb
  begin
    next_prdata = 32'h00000000;
    if (addr_hi_zero)
    begin
      case (reg_idx)
        TGF_IDX_FINE_TRIM: next_prdata = {26'h0, fine_trim_reg};
        TGF_IDX_GAIN_LEVEL: next_prdata = {24'h0, tx_gain_level};
        TGF_IDX_UPDATE_CTRL: next_prdata = {24'h0, tx_gain_update_control};
        TGF_IDX_FORMAT: next_prdata = {24'h0, io_format_config};
        TGF_IDX_GAIN_STATUS: next_prdata = {14'h0, ramp_busy, gain_pending, gain_target, applied};
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd_en)
      prdata <= next_prdata;
  end

  // assertions
  a_gain_reset_ff: assert property (@(posedge pclk)
    $rose(presetn) |-> tx_gain_level == TGF_RST_GAIN)
    else $error("gain level not FF after reset");

  a_immediate_apply: assert property (@(posedge pclk) disable iff (!presetn)
    !gain_sync_enable && $past(!gain_sync_enable) |-> gain_target == $past(tx_gain_level))
    else $error("unsynchronised gain not applied after write");

  a_sync_hold_target: assert property (@(posedge pclk) disable iff (!presetn)
    gain_sync_enable && $past(gain_sync_enable) && !$past(pd_fall) |->
    $stable(gain_target))
    else $error("synced gain changed without power-down edge");

  a_sync_on_edge: assert property (@(posedge pclk) disable iff (!presetn)
    gain_sync_enable && pd_fall |=>
    gain_target == $past(tx_gain_level) && gain_pending == $past(level_write))
    else $error("gain not taken on power-down falling edge");

  a_both_channels: assert property (@(posedge pclk) disable iff (!presetn)
    tx_gain_stage == tx_gain_stage_b)
    else $error("transmit channels differ in gain");

  a_tx_format_bit: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && pstrb[0] && sel_format |=>
    format_cfg.tx_twos == $past(pwdata[7]) && format_cfg.rx_twos == $past(pwdata[6]))
    else $error("format bits not taken from write");

  a_edge_select: assert property (@(posedge pclk) disable iff (!presetn)
    format_cfg.tx_fall_edge == io_format_config[5] && format_cfg.interp == io_format_config[1:0])
    else $error("edge or interpolation select mismatched");

  a_trim_reset: assert property (@(posedge pclk)
    $rose(presetn) |-> fine_trim == 6'sd0)
    else $error("fine trim not zero after reset");

  c_gain_write: cover property (@(posedge pclk) disable iff (!presetn)
    level_write);
  c_sync_apply: cover property (@(posedge pclk) disable iff (!presetn)
    gain_sync_enable && gain_pending && pd_fall);
  c_ramp_done: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(ramp_busy) && !gain_fast_settle);
  c_interp_x4: cover property (@(posedge pclk) disable iff (!presetn)
    format_cfg.interp == TGF_INTERP_X4);

endmodule
`default_nettype wire

/* dv/tb.sv */
// tb: self-checking bench for the transmit gain and data format registers.
// assumes tgf_pkg is compiled first; drives APB and the power-down pin itself.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tgf_pkg::*;
  localparam logic [11:0] A_TRIM = {2'b00, TGF_ADDR_FINE_TRIM};
  localparam logic [11:0] A_LVL = {2'b00, TGF_ADDR_GAIN_LEVEL};
  localparam logic [11:0] A_CTL = {2'b00, TGF_ADDR_UPDATE_CTRL};
  localparam logic [11:0] A_FMT = {2'b00, TGF_ADDR_FORMAT};
  localparam logic [11:0] A_STAT = {2'b00, TGF_ADDR_GAIN_STATUS};
  logic pclk, presetn, psel, penable, pwrite, pin, pready, pslverr, gain_ramping;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] tx_gain_stage, tx_gain_stage_b;
  logic signed [5:0] fine_trim;
  tgf_format_s format_cfg;
  int errors = 0;
  int checked = 0;

  // short ramp step keeps smooth-mode runs brief
  tgf_regs #(.RAMP_STEP_CYC(2)) tgf_regs_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_powerdown_pin(pin), .tx_gain_stage(tx_gain_stage),
    .tx_gain_stage_b(tx_gain_stage_b), .fine_trim(fine_trim), .format_cfg(format_cfg),
    .gain_ramping(gain_ramping));

  // 50 ns period clock
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic summarize;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic fail(input string m);
    errors++;
    $display("mismatch at %0t: %s", $time, m);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp)
      fail(m);
  endtask

  // one APB transfer; an idle edge follows so psel is never rewritten in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      fail("no pready");
      summarize;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk({31'h0, e}, 32'h0, "write error flag");
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp, "read data");
    chk({31'h0, e}, 32'h0, "read error flag");
  endtask

  // bounded wait for the applied gain; both channels must agree
  task automatic wait_gain(input logic [7:0] exp, input int lim);
    int n;
    n = 0;
    while (tx_gain_stage !== exp && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    if (tx_gain_stage !== exp)
    begin
      fail("gain not reached in time");
      summarize;
    end
    chk({24'h0, tx_gain_stage_b}, {24'h0, exp}, "channel b gain");
  endtask

  task automatic t_reset;
    chk({24'h0, tx_gain_stage}, 32'h0000_00FF, "reset gain");
    chk({24'h0, tx_gain_stage_b}, 32'h0000_00FF, "reset gain b");
    chk({26'h0, fine_trim}, 32'h0, "reset trim");
    chk({27'h0, format_cfg}, 32'h0, "reset format");
    rd(A_LVL, 32'h0000_00FF);
    rd(A_CTL, 32'h0);
    rd(A_FMT, 32'h0);
    rd(A_TRIM, 32'h0);
    $display("test reset done");
  endtask

  // fast mode must reach code 00 within a few cycles; a ramp would need hundreds
  task automatic t_fast;
    wr(A_CTL, 32'h0000_0010);
    wr(A_LVL, 32'h0000_0000);
    wait_gain(8'h00, 4);
    rd(A_LVL, 32'h0);
    $display("test fast done");
  endtask

  // sync mode holds the old gain until the pin falls
  task automatic t_sync;
    wr(A_CTL, 32'h0000_0050);
    wr(A_LVL, 32'h0000_0080);
    repeat (6) @(posedge pclk);
    chk({24'h0, tx_gain_stage}, 32'h0, "gain moved before pin edge");
    rd(A_STAT, 32'h0001_0000);
    pin <= 1'b0;
    wait_gain(8'h80, 8);
    pin <= 1'b1;
    wr(A_CTL, 32'h0000_0000);
    $display("test sync done");
  endtask

  // smooth mode: 16 codes at 2 cycles each must not land at once
  task automatic t_smooth;
    wr(A_LVL, 32'h0000_0090);
    repeat (4) @(posedge pclk);
    chk({31'h0, gain_ramping}, 32'h1, "not ramping");
    chk({31'h0, tx_gain_stage == 8'h90}, 32'h0, "gain jumped");
    wait_gain(8'h90, 60);
    $display("test smooth done");
  endtask

  task automatic t_format;
    logic [31:0] r;
    logic e;
    logic [7:0] v;
    for (int i = 0; i < 3; i++)
    begin
      v = (8'h80 >> i) | 8'(i); // interpolation code 11 never written
      wr(A_FMT, {24'h0, v});
      chk({27'h0, format_cfg}, {27'h0, v[7:5], v[1:0]}, "format bits");
      rd(A_FMT, {24'h0, v});
    end
    wr(A_FMT, 32'h0000_00E0);
    chk({27'h0, format_cfg}, 32'h0000_001C, "format all set");
    wr(A_TRIM, 32'h0000_001F);
    chk({26'h0, fine_trim}, 32'h0000_001F, "trim max negative");
    rd(A_TRIM, 32'h0000_001F);
    apb(1'b0, 12'h07C, 32'h0, r, e);
    chk({31'h0, e}, 32'h1, "unmapped read accepted");
    apb(1'b1, A_STAT, 32'h0000_0011, r, e);
    chk({31'h0, e}, 32'h1, "status write accepted");
    rd(A_LVL, 32'h0000_0090);
    // low byte strobe off: the gain write must be ignored
    pstrb <= 4'hE;
    wr(A_LVL, 32'h0000_0012);
    pstrb <= 4'hF;
    rd(A_LVL, 32'h0000_0090);
    $display("test format done");
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    pin = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_fast;
    t_sync;
    t_smooth;
    t_format;
    summarize;
  end
endmodule
`default_nettype wire
